// ===== design/rfdcr_cfg.svh
// Register map, field positions, reset values and timing constants of the driver config bank
// Functional notes
// - High count byte reads timer bits 15:8
// - Index 0x27 reads timer bits 7:0
// - Sixteen-bit count, both bytes read-only
// - Start loads reload; later writes wait
// - Mode bit 7 inverts driver two
// - Mode bit 6 inverts driver one
// - Enable bit gates both driver outputs
// - Mode field picks stage; two codes unsupported
// - Two-bit field picks carrier level reduction
// - Five-bit residual carrier percentage field
// - Full-swing bit overrides level reduction
// - Two-bit field selects modulation source
// - Invert modulation after source selection
// - Upper nibble sets extra modulation length
// - Load register upper nibble: first overshoot value
// - Load register lower nibble: load current trim
`ifndef RFDCR_CFG_SVH
`define RFDCR_CFG_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RFDCR_IDX_TMR_CTRL 8'h23
`define RFDCR_IDX_RELOAD_HI 8'h24
`define RFDCR_IDX_RELOAD_LO 8'h25
`define RFDCR_IDX_COUNT_HI 8'h26
`define RFDCR_IDX_COUNT_LO 8'h27
`define RFDCR_IDX_DRV_MODE 8'h28
`define RFDCR_IDX_AMP 8'h29
`define RFDCR_IDX_MOD_CTRL 8'h2a
`define RFDCR_IDX_LOAD_TRIM 8'h2b
// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define RFDCR_DM_INV_TWO 7
`define RFDCR_DM_INV_ONE 6
`define RFDCR_DM_EN 3
`define RFDCR_DM_MODE 2:0
`define RFDCR_DM_WMASK 8'hcf
`define RFDCR_AMP_RED 7:6
`define RFDCR_AMP_RES 4:0
`define RFDCR_AMP_WMASK 8'hdf
`define RFDCR_MC_OVS 7:4
`define RFDCR_MC_FULL 3
`define RFDCR_MC_INV 2
`define RFDCR_MC_SEL 1:0
`define RFDCR_LT_FIRST 7:4
`define RFDCR_LT_TRIM 3:0
`define RFDCR_TC_RUN 7
`define RFDCR_TC_SSN 6
`define RFDCR_TC_AUTO 3
`define RFDCR_TC_CLK 1:0
`define RFDCR_REG_RST 8'h00
// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define RFDCR_OM_HIZ 3'h0
`define RFDCR_OM_LOW 3'h1
`define RFDCR_OM_HIGH 3'h2
`define RFDCR_OM_PUSH 3'h4
`define RFDCR_OM_ODRAIN 3'h5
`define RFDCR_OM_PUSH_ALT 3'h7
`define RFDCR_SRC_ENV 2'h1
`define RFDCR_SRC_EXT 2'h2
`define RFDCR_TDIV_1 6'h00
`define RFDCR_TDIV_8 6'h07
`define RFDCR_TDIV_16 6'h0f
`define RFDCR_TDIV_32 6'h1f
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RFDCR_CLK_MHZ 125
`define RFDCR_TICK_NS 1000
`define RFDCR_TICK_CYC ((`RFDCR_TICK_NS * `RFDCR_CLK_MHZ) / 1000)
`define RFDCR_CARRIER_HALF_NS 40
`define RFDCR_CARRIER_HALF_CYC ((`RFDCR_CARRIER_HALF_NS * `RFDCR_CLK_MHZ) / 1000)
`endif

// ===== design/rfdcr_pkg.sv
// State types of the driver configuration bank
package rfdcr_pkg;
  typedef struct packed
  {
    logic [15:0] pre;
    logic [5:0] sub;
    logic [15:0] cnt;
    logic run;
    logic uf;
  } rfdcr_tmr_s;

  typedef struct packed
  {
    logic sync1;
    logic sync2;
    logic [7:0] div;
    logic carrier;
    logic mod_prev;
    logic [3:0] t1_cnt;
    logic [3:0] t2_cnt;
    logic one_out;
    logic one_oe;
    logic two_out;
    logic two_oe;
    logic mod_act;
    logic boost;
  } rfdcr_drv_s;

  typedef struct packed
  {
    logic tc_auto;
    logic [1:0] tc_clk;
    logic [15:0] reload;
    logic [7:0] drv_mode;
    logic [7:0] amp;
    logic [7:0] mod_ctrl;
    logic [7:0] load_trim;
    logic [31:0] prdata;
    logic pslverr;
    logic start;
    logic stop;
    logic red_en;
  } rfdcr_regs_s;
endpackage

// ===== design/rfdcr_wake_timer.sv
// Sixteen-bit wake-up down counter with reload and prescaler
`timescale 1ns/10ps
`include "rfdcr_cfg.svh"
module rfdcr_wake_timer
  import rfdcr_pkg::*;
#(
  parameter int TICK_CYC = `RFDCR_TICK_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] reload_value,
  input wire logic auto_restart,
  input wire logic [1:0] clk_sel,
  output logic [15:0] count,
  output logic running,
  output logic underflow
);
  rfdcr_tmr_s t_reg;
  rfdcr_tmr_s t_next;
  logic tick;
  logic [5:0] lim;

  if (TICK_CYC < 1 || TICK_CYC > 65535)
  begin : g_chk
    $error("TICK_CYC out of range");
  end

  always_comb
  begin
    t_next = t_reg;
    t_next.uf = 1'b0;
    tick = 1'b0;
    case (clk_sel)
      2'h0: lim = `RFDCR_TDIV_1;
      2'h1: lim = `RFDCR_TDIV_8;
      2'h2: lim = `RFDCR_TDIV_16;
      default: lim = `RFDCR_TDIV_32;
    endcase
    if (t_reg.run)
    begin
      if (t_reg.pre == 16'(TICK_CYC - 1))
      begin
        t_next.pre = '0;
        if (t_reg.sub >= lim)
        begin
          t_next.sub = '0;
          tick = 1'b1;
        end
        else
        begin
          t_next.sub = t_reg.sub + 6'h01;
        end
      end
      else
      begin
        t_next.pre = t_reg.pre + 16'h0001;
      end
    end
    if (tick)
    begin
      if (t_reg.cnt == 16'h0000)
      begin
        t_next.uf = 1'b1;
        if (auto_restart)
        begin
          t_next.cnt = reload_value;
        end
        else
        begin
          t_next.run = 1'b0;
        end
      end
      else
      begin
        t_next.cnt = t_reg.cnt - 16'h0001;
      end
    end
    if (stop)
    begin
      t_next.run = 1'b0;
    end
    if (start)
    begin
      t_next.cnt = reload_value;
      t_next.pre = '0;
      t_next.sub = '0;
      t_next.run = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_reg <= '0;
    end
    else
    begin
      t_reg <= t_next;
    end
  end

  assign count = t_reg.cnt;
  assign running = t_reg.run;
  assign underflow = t_reg.uf;
endmodule

// ===== design/rfdcr_tx_drive.sv
// Carrier, modulation path, overshoot pulses and antenna pin stage
`timescale 1ns/10ps
`include "rfdcr_cfg.svh"
module rfdcr_tx_drive
  import rfdcr_pkg::*;
#(
  parameter int CARRIER_HALF = `RFDCR_CARRIER_HALF_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic driver_enable,
  input wire logic driver_one_invert,
  input wire logic driver_two_invert,
  input wire logic [2:0] driver_output_mode,
  input wire logic [1:0] modulation_source_select,
  input wire logic modulation_invert,
  input wire logic [3:0] overshoot_extra_length,
  input wire logic [3:0] overshoot_first_value,
  input wire logic [4:0] residual_carrier,
  input wire logic coded_envelope_source,
  input wire logic external_signal_source,
  output logic antenna_driver_one_out,
  output logic antenna_driver_one_oe,
  output logic antenna_driver_two_out,
  output logic antenna_driver_two_oe,
  output logic modulation_active,
  output logic overshoot_boost
);
  rfdcr_drv_s d_reg;
  rfdcr_drv_s d_next;
  logic period;
  logic mod_raw;
  logic mod_sel;
  logic wave;
  logic v1;
  logic v2;

  if (CARRIER_HALF < 1 || CARRIER_HALF > 255)
  begin : g_chk
    $error("CARRIER_HALF out of range");
  end

  always_comb
  begin
    d_next = d_reg;
    d_next.sync1 = external_signal_source;
    d_next.sync2 = d_reg.sync1;
    period = 1'b0;
    if (d_reg.div == 8'(CARRIER_HALF - 1))
    begin
      d_next.div = '0;
      d_next.carrier = ~d_reg.carrier;
      period = ~d_reg.carrier;
    end
    else
    begin
      d_next.div = d_reg.div + 8'h01;
    end
    case (modulation_source_select)
      `RFDCR_SRC_ENV: mod_raw = coded_envelope_source;
      `RFDCR_SRC_EXT: mod_raw = d_reg.sync2;
      default: mod_raw = 1'b0;
    endcase
    mod_sel = mod_raw ^ modulation_invert;
    d_next.mod_prev = mod_sel;
    if (period && d_reg.t1_cnt != 4'h0)
    begin
      d_next.t1_cnt = d_reg.t1_cnt - 4'h1;
    end
    if (period && d_reg.t2_cnt != 4'h0)
    begin
      d_next.t2_cnt = d_reg.t2_cnt - 4'h1;
    end
    if (mod_sel && !d_reg.mod_prev)
    begin
      d_next.t1_cnt = overshoot_first_value;
      d_next.t2_cnt = 4'h0;
    end
    if (!mod_sel && d_reg.mod_prev)
    begin
      d_next.t2_cnt = overshoot_extra_length;
    end
    d_next.mod_act = mod_sel | (d_next.t2_cnt != 4'h0);
    d_next.boost = d_next.t1_cnt != 4'h0;
    wave = d_reg.carrier & ~(d_reg.mod_act & (residual_carrier == 5'h00));
    v1 = wave ^ driver_one_invert;
    v2 = wave ^ driver_two_invert;
    case (driver_output_mode)
      `RFDCR_OM_LOW:
      begin
        d_next.one_out = 1'b0;
        d_next.two_out = 1'b0;
        d_next.one_oe = 1'b1;
        d_next.two_oe = 1'b1;
      end
      `RFDCR_OM_HIGH:
      begin
        d_next.one_out = 1'b1;
        d_next.two_out = 1'b1;
        d_next.one_oe = 1'b1;
        d_next.two_oe = 1'b1;
      end
      `RFDCR_OM_PUSH, `RFDCR_OM_PUSH_ALT:
      begin
        d_next.one_out = v1;
        d_next.two_out = v2;
        d_next.one_oe = 1'b1;
        d_next.two_oe = 1'b1;
      end
      `RFDCR_OM_ODRAIN:
      begin
        d_next.one_out = 1'b0;
        d_next.two_out = 1'b0;
        d_next.one_oe = ~v1;
        d_next.two_oe = ~v2;
      end
      default:
      begin
        // Unsupported codes fall back to high impedance
        d_next.one_out = 1'b0;
        d_next.two_out = 1'b0;
        d_next.one_oe = 1'b0;
        d_next.two_oe = 1'b0;
      end
    endcase
    if (!driver_enable)
    begin
      d_next.one_out = 1'b0;
      d_next.two_out = 1'b0;
      d_next.one_oe = 1'b0;
      d_next.two_oe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d_reg <= '0;
    end
    else
    begin
      d_reg <= d_next;
    end
  end

  assign antenna_driver_one_out = d_reg.one_out;
  assign antenna_driver_one_oe = d_reg.one_oe;
  assign antenna_driver_two_out = d_reg.two_out;
  assign antenna_driver_two_oe = d_reg.two_oe;
  assign modulation_active = d_reg.mod_act;
  assign overshoot_boost = d_reg.boost;
endmodule

// ===== design/rfdcr_regs.sv
// APB register bank for the transmitter driver and wake-up timer readback
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "rfdcr_cfg.svh"
module rfdcr_regs
  import rfdcr_pkg::*;
#(
  parameter int TICK_CYC = `RFDCR_TICK_CYC,
  parameter int CARRIER_HALF = `RFDCR_CARRIER_HALF_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coded_envelope_source,
  input wire logic external_signal_source,
  output logic antenna_driver_one_out,
  output logic antenna_driver_one_oe,
  output logic antenna_driver_two_out,
  output logic antenna_driver_two_oe,
  output logic modulation_active,
  output logic overshoot_boost,
  output logic [1:0] carrier_level_reduction,
  output logic carrier_reduction_enable,
  output logic carrier_full_swing,
  output logic [4:0] residual_carrier,
  output logic [3:0] load_current_trim,
  output logic wake_timer_underflow
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rfdcr_regs_s r_reg;
  rfdcr_regs_s r_next;
  logic [7:0] idx;
  logic mapped;
  logic setup;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [15:0] wake_timer_count;
  logic wake_timer_running;
  logic [7:0] wake_timer_count_high;
  logic [7:0] wake_timer_count_low;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only the low byte lane is implemented; bits above read zero
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    case (idx)
      `RFDCR_IDX_TMR_CTRL,
      `RFDCR_IDX_RELOAD_HI,
      `RFDCR_IDX_RELOAD_LO,
      `RFDCR_IDX_COUNT_HI,
      `RFDCR_IDX_COUNT_LO,
      `RFDCR_IDX_DRV_MODE,
      `RFDCR_IDX_AMP,
      `RFDCR_IDX_MOD_CTRL,
      `RFDCR_IDX_LOAD_TRIM: mapped = (paddr[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // Write takes effect only at the completing access edge
  assign wr_fire = psel & penable & pwrite & pstrb[0] & ~r_reg.pslverr;

  // ----------------------------------------------------------------
  // Timer count readback
  // ----------------------------------------------------------------
  // count bytes follow hardware only
  assign wake_timer_count_high = wake_timer_count[15:8];
  assign wake_timer_count_low = wake_timer_count[7:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rbyte = 8'h00;
    case (idx)
      `RFDCR_IDX_TMR_CTRL:
      begin
        rbyte[`RFDCR_TC_RUN] = wake_timer_running;
        rbyte[`RFDCR_TC_AUTO] = r_reg.tc_auto;
        rbyte[`RFDCR_TC_CLK] = r_reg.tc_clk;
      end
      `RFDCR_IDX_RELOAD_HI: rbyte = r_reg.reload[15:8];
      `RFDCR_IDX_RELOAD_LO: rbyte = r_reg.reload[7:0];
      `RFDCR_IDX_COUNT_HI: rbyte = wake_timer_count_high;
      `RFDCR_IDX_COUNT_LO: rbyte = wake_timer_count_low;
      `RFDCR_IDX_DRV_MODE: rbyte = r_reg.drv_mode & `RFDCR_DM_WMASK;
      `RFDCR_IDX_AMP: rbyte = r_reg.amp & `RFDCR_AMP_WMASK;
      `RFDCR_IDX_MOD_CTRL: rbyte = r_reg.mod_ctrl;
      `RFDCR_IDX_LOAD_TRIM: rbyte = r_reg.load_trim;
      default: rbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.stop = 1'b0;
    // Read data and error are captured in the setup cycle, so the
    // access phase completes with no wait states
    if (setup)
    begin
      r_next.pslverr = ~mapped;
      r_next.prdata = (mapped && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;
    end
    if (wr_fire)
    begin
      case (idx)
        `RFDCR_IDX_TMR_CTRL:
        begin
          r_next.tc_auto = wbyte[`RFDCR_TC_AUTO];
          r_next.tc_clk = wbyte[`RFDCR_TC_CLK];
          if (wbyte[`RFDCR_TC_SSN])
          begin
            r_next.start = wbyte[`RFDCR_TC_RUN];
            r_next.stop = ~wbyte[`RFDCR_TC_RUN];
          end
        end
        `RFDCR_IDX_RELOAD_HI: r_next.reload[15:8] = wbyte;
        `RFDCR_IDX_RELOAD_LO: r_next.reload[7:0] = wbyte;
        `RFDCR_IDX_DRV_MODE: r_next.drv_mode = wbyte & `RFDCR_DM_WMASK;
        `RFDCR_IDX_AMP: r_next.amp = wbyte & `RFDCR_AMP_WMASK;
        `RFDCR_IDX_MOD_CTRL: r_next.mod_ctrl = wbyte;
        `RFDCR_IDX_LOAD_TRIM: r_next.load_trim = wbyte;
        default: r_next.reload = r_reg.reload;
      endcase
    end
    r_next.red_en = ~r_next.mod_ctrl[`RFDCR_MC_FULL];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '0;
      r_reg.drv_mode <= `RFDCR_REG_RST;
      r_reg.amp <= `RFDCR_REG_RST;
      r_reg.mod_ctrl <= `RFDCR_REG_RST;
      r_reg.load_trim <= `RFDCR_REG_RST;
      r_reg.red_en <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.pslverr & psel & penable;

  // ----------------------------------------------------------------
  // Analog settings
  // ----------------------------------------------------------------
  // fields drive straight from registers
  assign carrier_level_reduction = r_reg.amp[`RFDCR_AMP_RED];
  assign carrier_reduction_enable = r_reg.red_en;
  assign carrier_full_swing = r_reg.mod_ctrl[`RFDCR_MC_FULL];
  assign residual_carrier = r_reg.amp[`RFDCR_AMP_RES];
  assign load_current_trim = r_reg.load_trim[`RFDCR_LT_TRIM];

  // ----------------------------------------------------------------
  // Wake-up timer
  // ----------------------------------------------------------------
  rfdcr_wake_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(r_reg.start),
    .stop(r_reg.stop),
    .reload_value(r_reg.reload),
    .auto_restart(r_reg.tc_auto),
    .clk_sel(r_reg.tc_clk),
    .count(wake_timer_count),
    .running(wake_timer_running),
    .underflow(wake_timer_underflow)
  );

  // ----------------------------------------------------------------
  // Driver stage
  // ----------------------------------------------------------------
  rfdcr_tx_drive #(
    .CARRIER_HALF(CARRIER_HALF)
  ) u_drive (
    .pclk(pclk),
    .presetn(presetn),
    .driver_enable(r_reg.drv_mode[`RFDCR_DM_EN]),
    .driver_one_invert(r_reg.drv_mode[`RFDCR_DM_INV_ONE]),
    .driver_two_invert(r_reg.drv_mode[`RFDCR_DM_INV_TWO]),
    .driver_output_mode(r_reg.drv_mode[`RFDCR_DM_MODE]),
    .modulation_source_select(r_reg.mod_ctrl[`RFDCR_MC_SEL]),
    .modulation_invert(r_reg.mod_ctrl[`RFDCR_MC_INV]),
    .overshoot_extra_length(r_reg.mod_ctrl[`RFDCR_MC_OVS]),
    .overshoot_first_value(r_reg.load_trim[`RFDCR_LT_FIRST]),
    .residual_carrier(r_reg.amp[`RFDCR_AMP_RES]),
    .coded_envelope_source(coded_envelope_source),
    .external_signal_source(external_signal_source),
    .antenna_driver_one_out(antenna_driver_one_out),
    .antenna_driver_one_oe(antenna_driver_one_oe),
    .antenna_driver_two_out(antenna_driver_two_out),
    .antenna_driver_two_oe(antenna_driver_two_oe),
    .modulation_active(modulation_active),
    .overshoot_boost(overshoot_boost)
  );
endmodule

// ===== tb/rfdcr_antenna_model.sv
// Antenna-side model: modulation sources and resolved pin levels
`timescale 1ns/10ps
module rfdcr_antenna_model
(
  input wire logic pclk,
  input wire logic env_req,
  input wire logic ext_req,
  input wire logic one_out,
  input wire logic one_oe,
  input wire logic two_out,
  input wire logic two_oe,
  output logic coded_envelope_source,
  output logic external_signal_source,
  output logic pin_one,
  output logic pin_two
);
  // Envelope comes from the same clock domain
  always_ff @(posedge pclk)
  begin
    coded_envelope_source <= env_req;
  end
  // External pin is asynchronous, so it moves off the clock edge
  assign #3 external_signal_source = ext_req;
  // Released pins sit at the pull-up level
  assign pin_one = one_oe ? one_out : 1'b1;
  assign pin_two = two_oe ? two_out : 1'b1;
endmodule

// ===== tb/rfdcr_regs_assertions.sv
// Port-level checks of the driver config register bank
`timescale 1ns/10ps
`include "rfdcr_cfg.svh"
module rfdcr_regs_assertions
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [1:0] carrier_level_reduction,
  input wire logic carrier_reduction_enable,
  input wire logic carrier_full_swing,
  input wire logic [4:0] residual_carrier,
  input wire logic [3:0] load_current_trim
);
  logic wr;
  logic rd;
  logic amp_wr;
  assign wr = psel && penable && pwrite && pstrb[0] && paddr[11:10] == 2'h0;
  assign rd = psel && penable && !pwrite && paddr[11:10] == 2'h0;
  assign amp_wr = wr && paddr[9:2] == `RFDCR_IDX_AMP;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_red_off;
    carrier_full_swing |-> !carrier_reduction_enable;
  endproperty
  a_red_off: assert property (p_red_off) else $error("reduction still on");
  property p_red_on;
    !carrier_full_swing |-> carrier_reduction_enable;
  endproperty
  a_red_on: assert property (p_red_on) else $error("reduction still off");
  property p_swing_set;
    wr && paddr[9:2] == `RFDCR_IDX_MOD_CTRL |=> carrier_full_swing == $past(pwdata[3]);
  endproperty
  a_swing_set: assert property (p_swing_set) else $error("full swing not updated");
  property p_residual;
    amp_wr |=> residual_carrier == $past(pwdata[4:0]);
  endproperty
  a_residual: assert property (p_residual) else $error("residual not updated");
  property p_level;
    amp_wr |=> carrier_level_reduction == $past(pwdata[7:6]);
  endproperty
  a_level: assert property (p_level) else $error("level reduction not updated");
  property p_trim;
    wr && paddr[9:2] == `RFDCR_IDX_LOAD_TRIM |=> load_current_trim == $past(pwdata[3:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("load trim not updated");
  property p_res_hold;
    !$stable(residual_carrier) |-> $past(amp_wr);
  endproperty
  a_res_hold: assert property (p_res_hold) else $error("residual moved without write");
  property p_amp_rsvd;
    rd && paddr[9:2] == `RFDCR_IDX_AMP |-> prdata[5] == 1'b0;
  endproperty
  a_amp_rsvd: assert property (p_amp_rsvd) else $error("amplitude reserved bit set");
  property p_mode_rsvd;
    rd && paddr[9:2] == `RFDCR_IDX_DRV_MODE |-> prdata[5:4] == 2'h0;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode reserved bits set");
endmodule
bind rfdcr_regs rfdcr_regs_assertions u_rfdcr_regs_assertions (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .carrier_level_reduction, .carrier_reduction_enable,
  .carrier_full_swing, .residual_carrier, .load_current_trim);

// ===== tb/rfdcr_regs_test.sv
// Self-checking bench for the driver config register bank
`timescale 1ns/10ps
`include "rfdcr_cfg.svh"
module rfdcr_regs_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, env_req, ext_req, pin_one;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, load_current_trim;
  logic [7:0] q, v;
  logic env, ext, one_out, one_oe, two_out, two_oe, modulation_active, overshoot_boost, uf;
  logic uf_seen = 1'b0;
  logic carrier_reduction_enable, carrier_full_swing;
  logic [1:0] carrier_level_reduction;
  logic [4:0] residual_carrier;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] exp_rd [4] = '{8'hcf, 8'hdf, 8'hff, 8'hff};
  // Env, ext, expected, inv, sel
  logic [5:0] mcase [7] = '{6'h29, 6'h25, 6'h11, 6'h1a, 6'h16, 6'h30, 6'h33};
  rfdcr_regs #(.TICK_CYC(2), .CARRIER_HALF(2)) u_rfdcr_regs (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .coded_envelope_source(env),
    .external_signal_source(ext), .antenna_driver_one_out(one_out), .antenna_driver_one_oe(one_oe),
    .antenna_driver_two_out(two_out), .antenna_driver_two_oe(two_oe), .modulation_active,
    .overshoot_boost, .carrier_level_reduction, .carrier_reduction_enable, .carrier_full_swing,
    .residual_carrier, .load_current_trim, .wake_timer_underflow(uf));
  rfdcr_antenna_model u_rfdcr_antenna_model (.pclk, .env_req, .ext_req, .one_out, .one_oe,
    .two_out, .two_oe, .coded_envelope_source(env), .external_signal_source(ext), .pin_one,
    .pin_two());
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Generous ceiling; the sequence needs well under two thousand cycles
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    // The underflow pulse lasts one cycle, so keep a sticky copy
    if (uf === 1'b1)
      uf_seen <= 1'b1;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, env_req, ext_req} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 8'h23; i <= 8'h2b; i++)
    begin
      apb(1'b0, i[7:0], 8'h00);
      check(q, `RFDCR_REG_RST);
    end
    apb(1'b0, 8'h3f, 8'h00);
    check({q, err}, 9'h001);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `RFDCR_IDX_DRV_MODE + i[7:0], 8'hff);
      apb(1'b0, `RFDCR_IDX_DRV_MODE + i[7:0], 8'h00);
      check(q, exp_rd[i]);
    end
    tick(1);
    check({carrier_level_reduction, residual_carrier, load_current_trim}, 11'h7ff);
    check({carrier_full_swing, carrier_reduction_enable}, 2'b10);
    apb(1'b1, `RFDCR_IDX_RELOAD_HI, 8'h12);
    apb(1'b1, `RFDCR_IDX_RELOAD_LO, 8'h34);
    apb(1'b1, `RFDCR_IDX_TMR_CTRL, 8'hc0);
    apb(1'b1, `RFDCR_IDX_RELOAD_HI, 8'h55);
    apb(1'b0, `RFDCR_IDX_COUNT_HI, 8'h00);
    check(q, 8'h12);
    apb(1'b0, `RFDCR_IDX_COUNT_LO, 8'h00);
    check(q < 8'h34, 1'b1);
    apb(1'b1, `RFDCR_IDX_TMR_CTRL, 8'h40);
    apb(1'b0, `RFDCR_IDX_COUNT_LO, 8'h00);
    v = q;
    apb(1'b1, `RFDCR_IDX_COUNT_LO, 8'hff);
    apb(1'b0, `RFDCR_IDX_COUNT_LO, 8'h00);
    check(q, v);
    apb(1'b1, `RFDCR_IDX_TMR_CTRL, 8'hc0);
    apb(1'b0, `RFDCR_IDX_COUNT_HI, 8'h00);
    check(q, 8'h55);
    apb(1'b1, `RFDCR_IDX_TMR_CTRL, 8'h40);
    apb(1'b1, `RFDCR_IDX_RELOAD_HI, 8'h00);
    apb(1'b1, `RFDCR_IDX_RELOAD_LO, 8'h02);
    check(uf_seen, 1'b0);
    apb(1'b1, `RFDCR_IDX_TMR_CTRL, 8'hc0);
    tick(20);
    apb(1'b0, `RFDCR_IDX_TMR_CTRL, 8'h00);
    check({uf_seen, q}, 9'h100);
    apb(1'b1, `RFDCR_IDX_MOD_CTRL, 8'h00);
    apb(1'b1, `RFDCR_IDX_DRV_MODE, 8'hc4);
    tick(4);
    check({one_oe, two_oe, pin_one}, 3'b001);
    for (int m = 0; m < 8; m++)
    begin
      if (m == 3 || m == 6)
        continue;
      apb(1'b1, `RFDCR_IDX_DRV_MODE, {5'h01, m[2:0]});
      tick(4);
      if (m == 5)
        check({one_out, two_out}, 2'b00);
      else
        check({one_oe, two_oe}, {2{m != 0}});
      if (m == 1 || m == 2)
        check({one_out, two_out}, {2{m == 2}});
    end
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `RFDCR_IDX_DRV_MODE, {k[1:0], 6'h0c});
      repeat (4)
      begin
        tick(3);
        check(one_out ^ two_out, k[0] ^ k[1]);
      end
    end
    // No boost window during the source cases
    apb(1'b1, `RFDCR_IDX_LOAD_TRIM, 8'h0f);
    foreach (mcase[j])
    begin
      @(posedge pclk);
      {env_req, ext_req} <= mcase[j][5:4];
      apb(1'b1, `RFDCR_IDX_MOD_CTRL, {5'h00, mcase[j][2:0]});
      tick(6);
      check(modulation_active, mcase[j][3]);
    end
    apb(1'b1, `RFDCR_IDX_LOAD_TRIM, 8'h4f);
    check(overshoot_boost, 1'b0);
    @(posedge pclk);
    env_req <= 1'b1;
    apb(1'b1, `RFDCR_IDX_MOD_CTRL, 8'h41);
    tick(6);
    check(overshoot_boost, 1'b1);
    @(posedge pclk);
    env_req <= 1'b0;
    tick(4);
    check(modulation_active, 1'b1);
    tick(30);
    check(modulation_active, 1'b0);
    check(overshoot_boost, 1'b0);
    wrap_up();
  end
endmodule
